// ### logic/dcms_ctrl.sv
// Purpose: Two-channel DDR3 channel mapper, scheduler, scrambler and vref trainer
// Assumes: Host presents requests on a valid/ready port; modules described by SPD inputs
// Notes:   One queue slot per channel pair entry; link clock sampled as ordinary input
// Functional notes
// (R01) Single-cycle launch issues every clock; double-cycle launch only every second clock.
// (R02) At 1333 use CL 9, RCD 9, RP 9, CWL 7.
// (R03) At 1600 use CL 11, RCD 11, RP 11, CWL 8.
// (R04) Two modules per channel force double-cycle launch; one allows either.
// (R05) One populated channel receives every memory cycle.
// (R06) Symmetric zone spans from address zero up to the smaller channel's top.
// (R07) Symmetric zone interleaves; remainder is single-channel; both zones active together.
// (R08) First logical channel must hold at least as much memory as second.
// (R09) Interleaved zone alternates channel on every 64-byte line boundary.
// (R10) Opposite-channel requests may issue before earlier data returns, both simultaneously.
// (R11) Equal capacities with boundary at top give fully interleaved operation.
// (R12) Differing device density and width per channel do not limit interleaving.
// (R13) Run at slowest rate and timings of any installed module from SPD.
// (R14) All pending requests are weighed together; best one issues within command spacing.
// (R15) Other commands may slot between an access's commands without disturbing it; here an ACT or PRE holds off every command on its channel for RCD or RP.
// (R16) Requests to an open page are issued back to back first.
// (R17) Write data is scrambled with a pseudo-random pattern before the bus.
// (R18) Read and write vref settings step finely and are trained at cold boot; here only read vref is swept and write vref takes its result.
// (R19) Read data is descrambled with the same sequence used when written.
// (R20) Rows tracked per bank; different row needs precharge then activate.
`timescale 1ns/1ps
module dcms_ctrl #(
   parameter int QDEPTH = 4,
   parameter int CAPW   = 8
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // Population and SPD
   input  wire logic [1:0]                modules_per_channel_a,
   input  wire logic [1:0]                modules_per_channel_b,
   input  wire logic [CAPW-1:0]           cap_a,
   input  wire logic [CAPW-1:0]           cap_b,
   input  wire logic                      spd_slow_a,
   input  wire logic                      spd_slow_b,
   input  wire logic                      cmd_launch_double_req,
   input  wire logic                      swap_phys,
   // Host request
   input  wire logic                      req_valid,
   output logic                           req_ready,
   input  wire dcms_pkg::dcms_req_t       req,
   // Read return from the link
   input  wire logic                      link_clk,
   input  wire logic                      rd_ret_valid,
   input  wire logic [63:0]               rd_ret_data,
   output logic                           rdata_valid_r,
   output logic [63:0]                    rdata_r,
   // Vref training inputs
   input  wire logic                      cold_boot,
   input  wire logic                      train_pass,
   // Channel commands
   output dcms_pkg::dcms_dram_cmd_t       ch0_cmd_r,
   output dcms_pkg::dcms_dram_cmd_t       ch1_cmd_r,
   // Status
   output dcms_pkg::dcms_timing_t         timing_r,
   output logic                           single_cycle_cmd_launch,
   output logic                           dual_mode,
   output logic                           cfg_error,
   output logic [5:0]                     read_ref_voltage_r,
   output logic [5:0]                     write_ref_voltage_r,
   output logic                           train_done_r
);
   localparam int AW = $clog2(QDEPTH);

   // Queue storage
   dcms_pkg::dcms_req_t q_req_r [QDEPTH];
   logic [QDEPTH-1:0]   q_vld_r;
   logic [QDEPTH-1:0]   q_chan_r;
   logic [15:0]         open_row_r [2][8];
   logic [7:0]          row_open_r [2];
   logic [1:0]          launch_gap_r;
   logic [3:0]          bank_wait_r [2];
   logic [15:0]         scr_wr_r;
   logic [15:0]         scr_rd_r;
   logic [2:0]          lk_sync_r;
   logic [1:0]          rv_sync_r;
   logic [63:0]         rd_sync_r [2];
   logic [5:0]          best_r;
   logic                any_pass_r;

   // Population decode
   logic pop_a;
   logic pop_b;
   logic [CAPW-1:0] cap_small;
   assign pop_a     = (modules_per_channel_a != 2'h0);
   assign pop_b     = (modules_per_channel_b != 2'h0);
   assign dual_mode = pop_a && pop_b;
   assign cap_small = (cap_a < cap_b) ? cap_a : cap_b;
   assign cfg_error = dual_mode && (cap_a < cap_b); // R08

   // Launch mode: two modules per channel forces double-cycle
   always_comb begin
      single_cycle_cmd_launch = !cmd_launch_double_req; // R01
      if (modules_per_channel_a == 2'h2 || modules_per_channel_b == 2'h2) begin
         single_cycle_cmd_launch = 1'b0; // R04
      end
   end

   // Timing set from slowest module
   always_ff @(posedge clk) begin
      if (srst) begin
         timing_r <= '{dcms_pkg::DCMS_CL_1333, dcms_pkg::DCMS_RCD_1333,
                       dcms_pkg::DCMS_RP_1333, dcms_pkg::DCMS_CWL_1333};
      end else if ((pop_a && spd_slow_a) || (pop_b && spd_slow_b)) begin // R13
         timing_r <= '{dcms_pkg::DCMS_CL_1333, dcms_pkg::DCMS_RCD_1333,
                       dcms_pkg::DCMS_RP_1333, dcms_pkg::DCMS_CWL_1333}; // R02
      end else begin
         timing_r <= '{dcms_pkg::DCMS_CL_1600, dcms_pkg::DCMS_RCD_1600,
                       dcms_pkg::DCMS_RP_1600, dcms_pkg::DCMS_CWL_1600}; // R03
      end
   end

   // Channel mapping of an incoming address (logical 0 is channel A)
   function automatic logic map_chan(input logic [31:0] a);
      logic lc;
      logic [CAPW-1:0] line_hi;
      lc      = 1'b0;
      line_hi = a[31 -: CAPW];
      if (!dual_mode) begin
         lc = !pop_a; // R05
      end else if ({1'b0, line_hi} < {cap_small, 1'b0}) begin
         lc = a[dcms_pkg::DCMS_LINE_BIT]; // R06 R09 R11 R12
      end else begin
         lc = 1'b0; // R07
      end
      return lc ^ swap_phys;
   endfunction

   // Free slot search
   logic [AW-1:0] free_idx;
   logic          has_free;
   always_comb begin
      free_idx = '0;
      has_free = 1'b0;
      for (int i = QDEPTH - 1; i >= 0; i--) begin
         if (!q_vld_r[i]) begin
            free_idx = AW'(i);
            has_free = 1'b1;
         end
      end
   end
   assign req_ready = has_free;

   // Per-channel pick: open-page hit first, else lowest index
   logic [AW-1:0] pick_idx [2];
   logic          pick_ok  [2];
   logic          pick_hit [2];
   generate
      for (genvar c = 0; c < 2; c++) begin : g_pick
         always_comb begin
            logic [2:0] bk;
            bk          = '0;
            pick_idx[c] = '0;
            pick_ok[c]  = 1'b0;
            pick_hit[c] = 1'b0;
            for (int i = QDEPTH - 1; i >= 0; i--) begin // R14
               bk = q_req_r[i].addr[dcms_pkg::DCMS_BANK_LSB +: 3];
               if (q_vld_r[i] && q_chan_r[i] == 1'(c) && !pick_hit[c]) begin
                  if (row_open_r[c][bk] && open_row_r[c][bk] ==
                      q_req_r[i].addr[dcms_pkg::DCMS_ROW_LSB +: 16]) begin
                     pick_idx[c] = AW'(i); // R16
                     pick_hit[c] = 1'b1;
                     pick_ok[c]  = 1'b1;
                  end else begin
                     pick_idx[c] = AW'(i);
                     pick_ok[c]  = 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // Launch slot
   logic launch_en;
   assign launch_en = single_cycle_cmd_launch || (launch_gap_r == 2'h0); // R01
   always_ff @(posedge clk) begin
      if (srst) begin
         launch_gap_r <= 2'h0;
      end else begin
         launch_gap_r <= (launch_en && !single_cycle_cmd_launch) ? 2'h1 : 2'h0;
      end
   end

   // Queue fill and retire
   logic [QDEPTH-1:0] retire;
   always_ff @(posedge clk) begin
      if (srst) begin
         q_vld_r <= '0;
      end else begin
         for (int i = 0; i < QDEPTH; i++) begin
            if (retire[i]) begin
               q_vld_r[i] <= 1'b0;
            end
         end
         if (req_valid && has_free) begin
            q_vld_r[free_idx]  <= 1'b1;
            q_req_r[free_idx]  <= req;
            q_chan_r[free_idx] <= map_chan(req.addr);
         end
      end
   end

   // Command issue per channel, both channels in parallel
   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         dcms_pkg::dcms_dram_cmd_t cmd_nxt;
         logic [2:0]  bk;
         logic [15:0] rw;
         assign bk = q_req_r[pick_idx[c]].addr[dcms_pkg::DCMS_BANK_LSB +: 3];
         assign rw = q_req_r[pick_idx[c]].addr[dcms_pkg::DCMS_ROW_LSB +: 16];
         always_comb begin
            cmd_nxt       = '0;
            cmd_nxt.cmd   = dcms_pkg::DCMS_CMD_NOP;
            cmd_nxt.bank  = bk;
            cmd_nxt.row   = rw;
            if (pick_ok[c] && launch_en && bank_wait_r[c] == 4'h0) begin // R10 R15
               if (!row_open_r[c][bk]) begin
                  cmd_nxt.cmd = dcms_pkg::DCMS_CMD_ACT; // R20
               end else if (!pick_hit[c]) begin
                  cmd_nxt.cmd = dcms_pkg::DCMS_CMD_PRE; // R20
               end else begin
                  cmd_nxt.cmd = q_req_r[pick_idx[c]].we ? dcms_pkg::DCMS_CMD_WR
                                                       : dcms_pkg::DCMS_CMD_RD;
                  cmd_nxt.wdata = q_req_r[pick_idx[c]].data ^ {4{scr_wr_r}}; // R17
               end
            end
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               row_open_r[c]  <= '0;
               bank_wait_r[c] <= 4'h0;
            end else begin
               if (bank_wait_r[c] != 4'h0) begin
                  bank_wait_r[c] <= bank_wait_r[c] - 4'h1;
               end
               case (cmd_nxt.cmd)
                  dcms_pkg::DCMS_CMD_ACT: begin
                     row_open_r[c][bk] <= 1'b1;
                     open_row_r[c][bk] <= rw;
                     bank_wait_r[c]    <= timing_r.rcd - 4'h1; // R15
                  end
                  dcms_pkg::DCMS_CMD_PRE: begin
                     row_open_r[c][bk] <= 1'b0;
                     bank_wait_r[c]    <= timing_r.rp - 4'h1;
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // Retire one queue entry per channel on read or write
   always_comb begin
      for (int i = 0; i < QDEPTH; i++) begin
         retire[i] = 1'b0;
      end
      if (g_ch[0].cmd_nxt.cmd inside {dcms_pkg::DCMS_CMD_RD, dcms_pkg::DCMS_CMD_WR}) begin
         retire[pick_idx[0]] = 1'b1;
      end
      if (g_ch[1].cmd_nxt.cmd inside {dcms_pkg::DCMS_CMD_RD, dcms_pkg::DCMS_CMD_WR}) begin
         retire[pick_idx[1]] = 1'b1;
      end
   end

   // Registered channel command outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         ch0_cmd_r <= '{dcms_pkg::DCMS_CMD_NOP, 3'h0, 16'h0000, 64'h0};
         ch1_cmd_r <= '{dcms_pkg::DCMS_CMD_NOP, 3'h0, 16'h0000, 64'h0};
      end else begin
         ch0_cmd_r <= g_ch[0].cmd_nxt;
         ch1_cmd_r <= g_ch[1].cmd_nxt;
      end
   end

   // Write scrambler advances once per clock with a write on either channel
   always_ff @(posedge clk) begin
      if (srst) begin
         scr_wr_r <= dcms_pkg::DCMS_SCR_SEED;
      end else if (g_ch[0].cmd_nxt.cmd == dcms_pkg::DCMS_CMD_WR ||
                   g_ch[1].cmd_nxt.cmd == dcms_pkg::DCMS_CMD_WR) begin
         scr_wr_r <= {1'b0, scr_wr_r[15:1]} ^ (scr_wr_r[0] ? dcms_pkg::DCMS_SCR_TAPS
                                                           : 16'h0000); // R17
      end
   end

   // Link clock, read strobe and read data synchronisers; return edge on link clock rise
   always_ff @(posedge clk) begin
      if (srst) begin
         lk_sync_r    <= 3'h0;
         rv_sync_r    <= 2'h0;
         rd_sync_r[0] <= 64'h0;
         rd_sync_r[1] <= 64'h0;
      end else begin
         lk_sync_r    <= {lk_sync_r[1:0], link_clk};
         rv_sync_r    <= {rv_sync_r[0], rd_ret_valid};
         rd_sync_r[0] <= rd_ret_data;
         rd_sync_r[1] <= rd_sync_r[0];
      end
   end

   // Read descrambler follows the same sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         scr_rd_r      <= dcms_pkg::DCMS_SCR_SEED;
         rdata_valid_r <= 1'b0;
         rdata_r       <= 64'h0;
      end else begin
         rdata_valid_r <= 1'b0;
         if (lk_sync_r[1] && !lk_sync_r[2] && rv_sync_r[1]) begin
            rdata_r       <= rd_sync_r[1] ^ {4{scr_rd_r}}; // R19
            rdata_valid_r <= 1'b1;
            scr_rd_r      <= {1'b0, scr_rd_r[15:1]} ^
                             (scr_rd_r[0] ? dcms_pkg::DCMS_SCR_TAPS : 16'h0000);
         end
      end
   end

   // Vref training: sweep steps at cold boot, keep the highest passing step
   always_ff @(posedge clk) begin
      if (srst) begin
         read_ref_voltage_r  <= dcms_pkg::DCMS_VREF_MID;
         write_ref_voltage_r <= dcms_pkg::DCMS_VREF_MID;
         train_done_r        <= 1'b0;
         best_r              <= dcms_pkg::DCMS_VREF_MID;
         any_pass_r          <= 1'b0;
      end else if (cold_boot && !train_done_r) begin // R18
         if (train_pass) begin
            best_r     <= read_ref_voltage_r;
            any_pass_r <= 1'b1;
         end
         if (read_ref_voltage_r == dcms_pkg::DCMS_VREF_STEPS) begin
            train_done_r        <= 1'b1;
            // With no passing step at all the midpoint is kept
            read_ref_voltage_r  <= train_pass ? read_ref_voltage_r :
                                   any_pass_r ? best_r : dcms_pkg::DCMS_VREF_MID;
            write_ref_voltage_r <= train_pass ? read_ref_voltage_r :
                                   any_pass_r ? best_r : dcms_pkg::DCMS_VREF_MID;
         end else begin
            read_ref_voltage_r <= read_ref_voltage_r + 6'h01;
         end
      end
   end
endmodule : dcms_ctrl

// ### logic/dcms_pkg.sv
// Purpose: Shared constants and types for the two-channel DDR3 mapper and scheduler
// Assumes: Memory command clock drives the controller; no register bus
// Notes:   Timings are counted in memory clock cycles
package dcms_pkg;
   // Speed bins
   localparam logic [1:0] DCMS_RATE_1333 = 2'h0;
   localparam logic [1:0] DCMS_RATE_1600 = 2'h1;
   // Timings per bin
   localparam logic [3:0] DCMS_CL_1333   = 4'h9;
   localparam logic [3:0] DCMS_RCD_1333  = 4'h9;
   localparam logic [3:0] DCMS_RP_1333   = 4'h9;
   localparam logic [3:0] DCMS_CWL_1333  = 4'h7;
   localparam logic [3:0] DCMS_CL_1600   = 4'hB;
   localparam logic [3:0] DCMS_RCD_1600  = 4'hB;
   localparam logic [3:0] DCMS_RP_1600   = 4'hB;
   localparam logic [3:0] DCMS_CWL_1600  = 4'h8;
   // Address layout: 64-byte lines, line bit selects channel in interleave zone
   localparam int DCMS_LINE_BIT = 6;
   localparam int DCMS_BANK_LSB = 7;
   localparam int DCMS_ROW_LSB  = 10;
   // Scrambler seed and polynomial taps (16-bit LFSR)
   localparam logic [15:0] DCMS_SCR_SEED = 16'hACE1;
   localparam logic [15:0] DCMS_SCR_TAPS = 16'hB400;
   // Reference voltage training
   localparam logic [5:0] DCMS_VREF_MID   = 6'h20;
   localparam logic [5:0] DCMS_VREF_STEPS = 6'h3F;

   // DRAM commands
   typedef enum logic [4:0] {
      DCMS_CMD_NOP = 5'b00001,
      DCMS_CMD_ACT = 5'b00010,
      DCMS_CMD_PRE = 5'b00100,
      DCMS_CMD_RD  = 5'b01000,
      DCMS_CMD_WR  = 5'b10000
   } dcms_cmd_t;

   // Host request
   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [63:0] data;
   } dcms_req_t;

   // Command to one physical channel
   typedef struct packed {
      dcms_cmd_t   cmd;
      logic [2:0]  bank;
      logic [15:0] row;
      logic [63:0] wdata;
   } dcms_dram_cmd_t;

   // Active timing set
   typedef struct packed {
      logic [3:0] cl;
      logic [3:0] rcd;
      logic [3:0] rp;
      logic [3:0] cwl;
   } dcms_timing_t;
endpackage : dcms_pkg

// ### verif/dcms_ctrl_properties.sv
// Purpose: Port checks for the two-channel mapper and scheduler
// Assumes: Sees only the top module ports
// Notes:   Bound into every dcms_ctrl instance
`timescale 1ns/1ps
module dcms_ctrl_properties #(
   parameter int CAPW = 8
) (
   // Clock, reset and population
   input wire logic                     clk,
   input wire logic                     srst,
   input wire logic [1:0]               modules_per_channel_a,
   input wire logic [1:0]               modules_per_channel_b,
   input wire logic [CAPW-1:0]          cap_a,
   input wire logic [CAPW-1:0]          cap_b,
   input wire logic                     cmd_launch_double_req,
   // Outputs watched
   input wire dcms_pkg::dcms_dram_cmd_t ch0_cmd_r,
   input wire dcms_pkg::dcms_dram_cmd_t ch1_cmd_r,
   input wire dcms_pkg::dcms_timing_t   timing_r,
   input wire logic                     single_cycle_cmd_launch,
   input wire logic                     dual_mode,
   input wire logic                     cfg_error,
   input wire logic [5:0]               read_ref_voltage_r,
   input wire logic [5:0]               write_ref_voltage_r,
   input wire logic                     rdata_valid_r
);
   localparam logic [15:0] T1333 = {dcms_pkg::DCMS_CL_1333, dcms_pkg::DCMS_RCD_1333,
                                    dcms_pkg::DCMS_RP_1333, dcms_pkg::DCMS_CWL_1333};
   localparam logic [15:0] T1600 = {dcms_pkg::DCMS_CL_1600, dcms_pkg::DCMS_RCD_1600,
                                    dcms_pkg::DCMS_RP_1600, dcms_pkg::DCMS_CWL_1600};
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // A command standing on each channel
   sequence s_busy0; ch0_cmd_r.cmd != dcms_pkg::DCMS_CMD_NOP; endsequence
   sequence s_busy1; ch1_cmd_r.cmd != dcms_pkg::DCMS_CMD_NOP; endsequence
   a_spacing_ch0: assert property (!single_cycle_cmd_launch ##0 s_busy0 |=> not s_busy0)
      else $error("channel 0 command too close in double launch");
   a_spacing_ch1: assert property (!single_cycle_cmd_launch ##0 s_busy1 |=> not s_busy1)
      else $error("channel 1 command too close in double launch");
   a_two_modules: assert property ((modules_per_channel_a == 2'h2 ||
      modules_per_channel_b == 2'h2 || cmd_launch_double_req) |-> !single_cycle_cmd_launch)
      else $error("single launch where double launch is required");
   a_timing_set: assert property (timing_r == T1333 || timing_r == T1600)
      else $error("timing set matches no speed bin");
   a_single_chan: assert property ((modules_per_channel_a == 2'h0 ||
      modules_per_channel_b == 2'h0) |-> !dual_mode)
      else $error("dual mode with one channel empty");
   a_dual_chan: assert property ((modules_per_channel_a != 2'h0 &&
      modules_per_channel_b != 2'h0) |-> dual_mode)
      else $error("single mode with both channels populated");
   a_size_order: assert property (dual_mode && cap_a < cap_b |-> cfg_error)
      else $error("smaller first channel not flagged");
   a_vref_reset: assert property ($fell(srst) |-> read_ref_voltage_r ==
      dcms_pkg::DCMS_VREF_MID && write_ref_voltage_r == dcms_pkg::DCMS_VREF_MID)
      else $error("reference voltage not at midpoint after reset");
   a_rdata_pulse: assert property (rdata_valid_r |=> !rdata_valid_r)
      else $error("read data valid longer than one cycle");
endmodule : dcms_ctrl_properties

bind dcms_ctrl dcms_ctrl_properties #(.CAPW(CAPW)) u_props (
   .clk, .srst, .modules_per_channel_a, .modules_per_channel_b, .cap_a, .cap_b,
   .cmd_launch_double_req, .ch0_cmd_r, .ch1_cmd_r, .timing_r, .single_cycle_cmd_launch,
   .dual_mode, .cfg_error, .read_ref_voltage_r, .write_ref_voltage_r, .rdata_valid_r
);

// ### verif/dcms_mem_model.sv
// Purpose: Behavioural memory modules on both channels
// Assumes: Commands stand one clock; read words return over the link clock
// Notes:   Link clock stands still between returned words
`timescale 1ns/1ps
module dcms_mem_model (
   // Clock and pace
   input wire logic                     clk,
   input wire logic                     slow,
   // Commands from the controller
   input wire dcms_pkg::dcms_dram_cmd_t ch0_cmd_r,
   input wire dcms_pkg::dcms_dram_cmd_t ch1_cmd_r,
   // Read return link
   output logic                         link_clk,
   output logic                         rd_ret_valid,
   output logic [63:0]                  rd_ret_data
);
   logic [63:0] mem [int];
   logic [63:0] q [$];
   // Store scrambled writes and queue reads by channel, bank and row
   task automatic snoop(input dcms_pkg::dcms_dram_cmd_t c, input logic ch);
      int k;
      k = int'({ch, c.bank, c.row});
      if (c.cmd == dcms_pkg::DCMS_CMD_WR) mem[k] = c.wdata;
      if (c.cmd == dcms_pkg::DCMS_CMD_RD) q.push_back(mem.exists(k) ? mem[k] : 64'h0);
   endtask : snoop
   always @(posedge clk) begin
      snoop(ch0_cmd_r, 1'b0);
      snoop(ch1_cmd_r, 1'b1);
   end
   // One link clock per word, data flipped once released
   initial begin
      link_clk = 1'b0;
      rd_ret_valid = 1'b0;
      rd_ret_data = 64'h0;
      forever begin
         wait (q.size() != 0);
         if (slow) #2000;
         else #200;
         rd_ret_data = q.pop_front();
         rd_ret_valid = 1'b1;
         #200 link_clk = 1'b1;
         #200 link_clk = 1'b0;
         rd_ret_valid = 1'b0;
         rd_ret_data = ~rd_ret_data;
      end
   end
endmodule : dcms_mem_model

// ### verif/tb.sv
// Purpose: Self-checking bench of the two-channel mapper and scheduler
// Assumes: Inputs change on the falling clock edge
// Notes:   Memory model answers reads over the link clock
`timescale 1ns/1ps
module tb;
   logic clk, srst, cmd_launch_double_req, swap_phys, spd_slow_a, spd_slow_b, slow;
   logic req_valid, req_ready, link_clk, rd_ret_valid, rdata_valid_r, cold_boot;
   logic train_pass, single_cycle_cmd_launch, dual_mode, cfg_error, train_done_r;
   logic [1:0] modules_per_channel_a, modules_per_channel_b;
   logic [7:0] cap_a, cap_b;
   logic [63:0] rd_ret_data, rdata_r, wd, rd;
   logic [5:0] read_ref_voltage_r, write_ref_voltage_r;
   dcms_pkg::dcms_req_t req;
   dcms_pkg::dcms_dram_cmd_t ch0_cmd_r, ch1_cmd_r;
   dcms_pkg::dcms_timing_t timing_r;
   int num_errors, comparisons, r0, r1, v;
   localparam logic [15:0] T1333 = {dcms_pkg::DCMS_CL_1333, dcms_pkg::DCMS_RCD_1333,
                                    dcms_pkg::DCMS_RP_1333, dcms_pkg::DCMS_CWL_1333};
   localparam logic [15:0] T1600 = {dcms_pkg::DCMS_CL_1600, dcms_pkg::DCMS_RCD_1600,
                                    dcms_pkg::DCMS_RP_1600, dcms_pkg::DCMS_CWL_1600};
   dcms_ctrl #(.QDEPTH(4), .CAPW(8)) dut (.clk, .srst, .modules_per_channel_a,
      .modules_per_channel_b, .cap_a, .cap_b, .spd_slow_a, .spd_slow_b,
      .cmd_launch_double_req, .swap_phys, .req_valid, .req_ready, .req, .link_clk,
      .rd_ret_valid, .rd_ret_data, .rdata_valid_r, .rdata_r, .cold_boot, .train_pass,
      .ch0_cmd_r, .ch1_cmd_r, .timing_r, .single_cycle_cmd_launch, .dual_mode,
      .cfg_error, .read_ref_voltage_r, .write_ref_voltage_r, .train_done_r);
   dcms_mem_model u_mem (.clk, .slow, .ch0_cmd_r, .ch1_cmd_r, .link_clk,
      .rd_ret_valid, .rd_ret_data);
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic do_reset;
      srst = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
   endtask : do_reset
   task automatic send(input logic we, input logic [31:0] addr, input logic [63:0] data);
      int n;
      @(negedge clk);
      req = '{we: we, addr: addr, data: data};
      req_valid = 1'b1;
      for (n = 0; n < 500 && req_ready !== 1'b1; n++) @(negedge clk);
      check({63'h0, req_ready}, 64'h1);
      @(negedge clk);
      req_valid = 1'b0;
   endtask : send
   // Count accesses per channel and returned words
   task automatic watch(input int n);
      r0 = 0;
      r1 = 0;
      v = 0;
      repeat (n) begin
         @(negedge clk);
         r0 += int'(ch0_cmd_r.cmd inside {dcms_pkg::DCMS_CMD_RD, dcms_pkg::DCMS_CMD_WR});
         r1 += int'(ch1_cmd_r.cmd inside {dcms_pkg::DCMS_CMD_RD, dcms_pkg::DCMS_CMD_WR});
         v += int'(rdata_valid_r === 1'b1);
      end
   endtask : watch
   // Write then read back one word through the scrambler
   task automatic t_roundtrip(input logic [63:0] d);
      bit got;
      got = 1'b0;
      send(1'b1, 32'h0000_0000, d);
      repeat (300) begin
         @(negedge clk);
         if (!got && ch0_cmd_r.cmd == dcms_pkg::DCMS_CMD_WR) {got, wd} = {1'b1, ch0_cmd_r.wdata};
         if (!got && ch1_cmd_r.cmd == dcms_pkg::DCMS_CMD_WR) {got, wd} = {1'b1, ch1_cmd_r.wdata};
      end
      check({63'h0, got && wd !== d}, 64'h1);
      send(1'b0, 32'h0000_0000, 64'h0);
      rd = ~d;
      repeat (600) begin
         @(negedge clk);
         if (rdata_valid_r === 1'b1) begin
            rd = rdata_r;
            break;
         end
      end
      check(rd, d);
      $display("roundtrip done");
   endtask : t_roundtrip
   task automatic t_launch;
      check({63'h0, single_cycle_cmd_launch}, 64'h1);
      cmd_launch_double_req = 1'b1;
      @(negedge clk);
      check({63'h0, single_cycle_cmd_launch}, 64'h0);
      cmd_launch_double_req = 1'b0;
      modules_per_channel_a = 2'h2;
      @(negedge clk);
      check({63'h0, single_cycle_cmd_launch}, 64'h0);
      modules_per_channel_a = 2'h1;
      cap_b = 8'h20;
      @(negedge clk);
      check({63'h0, cfg_error}, 64'h1);
      cap_b = 8'h10;
      @(negedge clk);
      check({63'h0, cfg_error}, 64'h0);
      $display("launch done");
   endtask : t_launch
   // Neighbouring lines, back to back
   task automatic t_lines(input int e0, input int e1);
      // Count from the first request on, since an open-page read issues at once
      fork
         watch(400);
         begin
            send(1'b0, 32'h0000_0000, 64'h0);
            send(1'b0, 32'h0000_0040, 64'h0);
         end
      join
      check(64'(r0), 64'(e0));
      check(64'(r1), 64'(e1));
      check(64'(v), 64'h2);
      check({63'h0, dual_mode}, {63'h0, e1 != 0});
      $display("lines done");
   endtask : t_lines
   task automatic t_slow;
      spd_slow_a = 1'b1;
      cold_boot = 1'b1;
      train_pass = 1'b1;
      slow = 1'b1;
      do_reset();
      repeat (4) @(negedge clk);
      check(64'(timing_r), 64'(T1333));
      for (int n = 0; n < 900 && train_done_r !== 1'b1; n++) @(negedge clk);
      check({63'h0, train_done_r}, 64'h1);
      check(64'(read_ref_voltage_r), 64'(dcms_pkg::DCMS_VREF_STEPS));
      check(64'(write_ref_voltage_r), 64'(dcms_pkg::DCMS_VREF_STEPS));
      cold_boot = 1'b0;
      t_roundtrip(64'h0123_4567_89AB_CDEF);
      $display("slow done");
   endtask : t_slow
   task automatic tally_and_finish;
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // Watchdog
   initial begin
      #3000000;
      num_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      {srst, cmd_launch_double_req, swap_phys, spd_slow_a, spd_slow_b} = 5'b10000;
      {slow, req_valid, cold_boot, train_pass} = 4'h0;
      req = '0;
      {modules_per_channel_a, modules_per_channel_b} = 4'h5;
      {cap_a, cap_b} = 16'h1010;
      num_errors = 0;
      comparisons = 0;
      do_reset();
      repeat (4) @(negedge clk);
      check(64'(timing_r), 64'(T1600));
      t_launch();
      t_roundtrip(64'h0);
      t_lines(1, 1);
      modules_per_channel_b = 2'h0;
      cap_b = 8'h00;
      cmd_launch_double_req = 1'b1;
      do_reset();
      t_lines(2, 0);
      cmd_launch_double_req = 1'b0;
      t_slow();
      tally_and_finish();
   end
endmodule : tb
